// ### hw/acl_defines.vh
// constants for the converter control block: offsets, fields, reset values, timing
`ifndef ACL_DEFINES_VH
`define ACL_DEFINES_VH
`define ACL_ADDR_W          3
`define ACL_OFF_SC          3'h0
`define ACL_OFF_RES_HI      3'h1
`define ACL_OFF_RES_LO      3'h2
`define ACL_OFF_CFG         3'h3
`define ACL_OFF_ISTAT       3'h4
`define ACL_OFF_IMASK       3'h5
`define ACL_SC_DONE         7
`define ACL_SC_IEN          6
`define ACL_SC_CONT         5
`define ACL_CH_MSB          4
`define ACL_CH_OFF          5'h1f
`define ACL_CFG_ACLK        0
`define ACL_CFG_EXT         1
`define ACL_CFG_BRKCLR      2
`define ACL_SC_RST          8'h1f
`define ACL_CFG_RST         8'h00
`define ACL_EV_DONE         0
`define ACL_EV_ABORT        1
`define ACL_EV_W            2
`define ACL_CONV_NS         4100
`define ACL_CLK_NS          10
`define ACL_CONV_CYC        ((`ACL_CONV_NS + `ACL_CLK_NS - 1) / `ACL_CLK_NS)
`endif

// ### hw/acl_sticky.v
// one sticky event bit, set wins over write-one-to-clear
`timescale 1ns/1ps
module acl_sticky (
  input  wire ref_clk_i,
  input  wire arst_n_i,
  input  wire set_i,
  input  wire clr_i,
  output reg  q_o
);
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end
endmodule // acl_sticky

// ### hw/acl_sar.v
// successive-approximation sequencer: one bit decided per step
`timescale 1ns/1ps
module acl_sar #(
  parameter WIDTH    = 10,
  parameter STEP_CYC = 41
) (
  input  wire             ref_clk_i,
  input  wire             arst_n_i,
  input  wire             start_i,
  input  wire             abort_i,
  input  wire             cmp_i,
  output reg  [WIDTH-1:0] trial_o,
  output reg              busy_o,
  output reg              done_o
);
  reg [15:0] step_cnt_reg;
  reg [WIDTH-1:0] bit_reg;
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trial_o      <= {WIDTH{1'b0}};
      bit_reg      <= {WIDTH{1'b0}};
      step_cnt_reg <= 16'h0000;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        busy_o <= 1'b0;
      end else if (start_i) begin
        busy_o       <= 1'b1;
        bit_reg      <= {1'b1, {(WIDTH-1){1'b0}}};
        trial_o      <= {1'b1, {(WIDTH-1){1'b0}}};
        step_cnt_reg <= 16'h0000;
      end else if (busy_o) begin
        if (step_cnt_reg == STEP_CYC[15:0] - 16'h0001) begin
          step_cnt_reg <= 16'h0000;
          // keep the trial bit if the input was at or above it, then try the next
          trial_o <= (cmp_i ? trial_o : (trial_o & ~bit_reg)) | (bit_reg >> 1);
          bit_reg <= bit_reg >> 1;
          if (bit_reg[0]) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end else begin
          step_cnt_reg <= step_cnt_reg + 16'h0001;
        end
      end
    end
  end
endmodule // acl_sar

// ### hw/acl_ctrl.v
// converter control: registers, low-power modes, break handling and interrupts
`timescale 1ns/1ps
`include "acl_defines.vh"
// Functional notes
// - interrupt enable set: request raised as done flag sets at completion
// - done flag sets at every conversion end regardless of enable
// - wait mode changes nothing: conversions and interrupts continue
// - single mode returns to low power after one conversion finishes
// - stop with async clock off aborts conversion, ends continuous mode
// - after such stop only a control write restarts conversions
// - result registers keep last completed value across an abort
// - stop with async clock on: normal operation continues
// - async clock on and external mode: trigger starts conversion in stop
// - waiting for trigger is low power; trigger gives one conversion then interrupt
// - break clear enable set: status clears in break, stay cleared
// - break clear enable clear: break accesses leave status bits unchanged
// - two-step clear begun before break completes after break
// - this variant has no trigger source; trigger input tied inactive
// - done flag read-only; cleared by control write or low result read
// - control write always aborts; it restarts unless channel field all ones or in stop with async clock off
module acl_ctrl #(
  parameter RES_W    = 10,
  parameter STEP_CYC = (`ACL_CONV_CYC + RES_W - 1) / RES_W,
  parameter HAS_EXT  = 0
) (
  input  wire                  ref_clk_i,
  input  wire                  arst_n_i,
  input  wire [`ACL_ADDR_W-1:0] addr_i,
  input  wire [7:0]            wdata_i,
  input  wire                  wr_i,
  input  wire                  rd_i,
  output reg  [7:0]            rdata_o,
  input  wire                  wait_mode_i,
  input  wire                  stop_mode_i,
  input  wire                  break_i,
  input  wire                  external_trigger_input_i,
  input  wire                  cmp_i,
  output reg  [RES_W-1:0]      trial_o,
  output reg                   conv_active_o,
  output reg                   conv_irq_o,
  output reg                   irq_o
);
  reg  [7:0] status_control_reg;
  reg  [7:0] cfg_reg;
  reg  [7:0] res_hi_reg;
  reg  [7:0] res_lo_reg;
  reg  [`ACL_EV_W-1:0] imask_reg;
  reg        hi_read_reg;
  reg        stop_d_reg;
  reg        restart_reg;
  wire [`ACL_EV_W-1:0] istat;
  wire [RES_W-1:0] sar_trial;
  wire       sar_busy;
  wire       sar_done;

  wire conv_irq_enable     = status_control_reg[`ACL_SC_IEN];
  wire continuous_conv_bit = status_control_reg[`ACL_SC_CONT];
  wire conv_done_flag      = status_control_reg[`ACL_SC_DONE];
  wire [4:0] channel_select_field = status_control_reg[`ACL_CH_MSB:0];
  wire async_clock_enable  = cfg_reg[`ACL_CFG_ACLK];
  wire ext_mode            = cfg_reg[`ACL_CFG_EXT];
  wire break_clear_enable  = cfg_reg[`ACL_CFG_BRKCLR];
  // status may be cleared under break only when clearing is enabled
  wire clr_ok = !break_i || break_clear_enable;

  wire sc_wr    = wr_i && (addr_i == `ACL_OFF_SC);
  wire lo_rd    = rd_i && (addr_i == `ACL_OFF_RES_LO);
  wire hi_rd    = rd_i && (addr_i == `ACL_OFF_RES_HI);
  // the control write itself is never blocked; only its status side effect is
  wire sc_start = sc_wr && (wdata_i[`ACL_CH_MSB:0] != `ACL_CH_OFF);
  wire stop_abort = stop_mode_i && !async_clock_enable;
  wire stop_entry = stop_abort && !stop_d_reg;
  // the trigger is only honoured where a source exists on this variant
  wire trig = (HAS_EXT != 0) && external_trigger_input_i;
  wire trig_start = trig && ext_mode && async_clock_enable && !sar_busy
                    && channel_select_field != `ACL_CH_OFF;
  // continuous restart is suppressed whenever stop aborted the sequence
  wire cont_start = restart_reg && !stop_abort && !ext_mode;
  // a control write decides alone, so an all-ones write also cancels a pending restart
  wire start = !stop_abort
               && (sc_start || (!sc_wr && (cont_start || trig_start)));
  wire abort = stop_entry || sc_wr;

  acl_sar #(
    .WIDTH    (RES_W),
    .STEP_CYC (STEP_CYC)
  ) u_sar (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .start_i   (start),
    // a write that starts nothing must still stop the running conversion
    .abort_i   (abort && !start),
    .cmp_i     (cmp_i),
    .trial_o   (sar_trial),
    .busy_o    (sar_busy),
    .done_o    (sar_done)
  );

  wire istat_clr_wr = wr_i && (addr_i == `ACL_OFF_ISTAT) && clr_ok;
  wire [`ACL_EV_W-1:0] ev_set = {stop_entry && sar_busy, sar_done};
  genvar g;
  generate
    for (g = 0; g < `ACL_EV_W; g = g + 1) begin : g_ev
      acl_sticky u_ev (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .set_i     (ev_set[g]),
        .clr_i     (istat_clr_wr && wdata_i[g]),
        .q_o       (istat[g])
      );
    end
  endgenerate

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_control_reg <= `ACL_SC_RST;
      cfg_reg            <= `ACL_CFG_RST;
      res_hi_reg         <= 8'h00;
      res_lo_reg         <= 8'h00;
      imask_reg          <= {`ACL_EV_W{1'b0}};
      hi_read_reg        <= 1'b0;
      stop_d_reg         <= 1'b0;
      restart_reg        <= 1'b0;
    end else begin
      stop_d_reg  <= stop_abort;
      restart_reg <= 1'b0;
      if (sc_wr) begin
        status_control_reg[6:0] <= wdata_i[6:0];
      end
      if (wr_i && addr_i == `ACL_OFF_CFG) begin
        cfg_reg <= {5'h00, wdata_i[2:0]};
      end
      if (wr_i && addr_i == `ACL_OFF_IMASK) begin
        imask_reg <= wdata_i[`ACL_EV_W-1:0];
      end
      // both steps of the high-then-low interlock: high read locks, low read releases
      if (hi_rd && clr_ok) begin
        hi_read_reg <= 1'b1;
      end else if (lo_rd && clr_ok) begin
        hi_read_reg <= 1'b0;
      end
      // set wins over the clearing events
      if (sar_done) begin
        status_control_reg[`ACL_SC_DONE] <= 1'b1;
        restart_reg <= continuous_conv_bit && !sc_wr;
      end else if ((sc_wr || lo_rd) && clr_ok) begin
        status_control_reg[`ACL_SC_DONE] <= 1'b0;
      end
      // results only move on completion, so an abort keeps the old value
      if (sar_done && !(hi_read_reg || (hi_rd && clr_ok))) begin
        res_hi_reg <= {{(16-RES_W){1'b0}}, sar_trial[RES_W-1:8]};
        res_lo_reg <= sar_trial[7:0];
      end
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o       <= 8'h00;
      trial_o       <= {RES_W{1'b0}};
      conv_active_o <= 1'b0;
      conv_irq_o    <= 1'b0;
      irq_o         <= 1'b0;
    end else begin
      trial_o       <= sar_trial;
      // analog side is powered only while a conversion runs
      conv_active_o <= sar_busy && !abort;
      conv_irq_o    <= conv_irq_enable && conv_done_flag;
      irq_o         <= |(istat & imask_reg);
      case (addr_i)
        `ACL_OFF_SC:     rdata_o <= rd_i ? status_control_reg : 8'h00;
        `ACL_OFF_RES_HI: rdata_o <= rd_i ? res_hi_reg : 8'h00;
        `ACL_OFF_RES_LO: rdata_o <= rd_i ? res_lo_reg : 8'h00;
        `ACL_OFF_CFG:    rdata_o <= rd_i ? cfg_reg : 8'h00;
        `ACL_OFF_ISTAT:  rdata_o <= rd_i ? {6'h00, istat} : 8'h00;
        `ACL_OFF_IMASK:  rdata_o <= rd_i ? {6'h00, imask_reg} : 8'h00;
        default:         rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // acl_ctrl

// ### sim/acl_ctrl_monitor.sv
// port-level assertion checker for the converter control block
`timescale 1ns/1ps
`include "acl_defines.vh"
module acl_ctrl_monitor (
  input wire                   ref_clk_i,
  input wire                   arst_n_i,
  input wire [`ACL_ADDR_W-1:0] addr_i,
  input wire [7:0]             wdata_i,
  input wire                   wr_i,
  input wire                   rd_i,
  input wire [7:0]             rdata_o,
  input wire                   stop_mode_i,
  input wire                   break_i,
  input wire                   conv_active_o,
  input wire                   conv_irq_o,
  input wire                   irq_o
);
  logic [7:0] cfg_reg;
  logic [7:0] mask_reg;
  // shadow copies so mode-dependent rules can be gated from the ports alone
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_reg  <= 8'h00;
      mask_reg <= 8'h00;
    end else begin
      if (wr_i && addr_i == `ACL_OFF_CFG) cfg_reg <= wdata_i;
      if (wr_i && addr_i == `ACL_OFF_IMASK) mask_reg <= wdata_i;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its slot");
  AST_IRQ_SRC: assert property ($rose(conv_irq_o) |->
    $past(conv_active_o, 2) || $past(conv_active_o, 3) || $past(conv_active_o, 4))
    else $error("conversion irq without a conversion");
  AST_WR_CLR: assert property (wr_i && addr_i == `ACL_OFF_SC && !break_i |-> ##2 !conv_irq_o)
    else $error("control write left irq set");
  AST_RDLO_CLR: assert property (rd_i && addr_i == `ACL_OFF_RES_LO && !break_i |-> ##2 !conv_irq_o)
    else $error("low result read left irq set");
  AST_IRQ_LVL: assert property (conv_irq_o && !wr_i && !rd_i && !$past(wr_i) && !$past(rd_i)
    |=> conv_irq_o) else $error("irq level dropped on its own");
  AST_STOP_ABORT: assert property ($rose(stop_mode_i) && !cfg_reg[0] |-> ##2 !conv_active_o)
    else $error("stop did not abort");
  AST_NO_RESUME: assert property ($fell(stop_mode_i) && !cfg_reg[0] && !wr_i && !conv_active_o
    ##1 !wr_i [*3] |-> !conv_active_o) else $error("resumed after stop");
  AST_BRK_HOLD: assert property (break_i && !cfg_reg[2] && conv_irq_o && rd_i
    && addr_i == `ACL_OFF_RES_LO |-> ##2 conv_irq_o) else $error("break read cleared flag");
  AST_MASK: assert property (irq_o |-> $past(mask_reg) != 8'h00)
    else $error("interrupt while fully masked");
  COV_IRQ: cover property ($rose(conv_irq_o));
  COV_INT: cover property ($rose(irq_o));
  COV_STOP: cover property ($rose(stop_mode_i) && conv_active_o);
endmodule // acl_ctrl_monitor
bind acl_ctrl acl_ctrl_monitor u_mon (.*);

// ### sim/acl_cmp_model.sv
// comparator model standing in for the analog side of the converter
`timescale 1ns/1ps
module acl_cmp_model (
  input  wire logic [9:0] trial_i,
  input  wire logic [9:0] level_i,
  output logic            cmp_o
);
  // input at or above the trial code keeps the bit under test
  assign cmp_o = level_i >= trial_i;
endmodule // acl_cmp_model

// ### sim/acl_ctrl_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "acl_defines.vh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module acl_ctrl_test;
  logic       ref_clk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0, cmp_i;
  logic       wait_mode_i = 0, stop_mode_i = 0, break_i = 0, external_trigger_input_i = 0;
  logic [2:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, d;
  logic [9:0] trial_o, level = 0;
  logic       conv_active_o, conv_irq_o, irq_o;
  int         err_count = 0, check_count = 0;
  logic [25:0] rows [3] = '{{10'h000, 16'h0000}, {10'h3ff, 16'h03ff}, {10'h2a5, 16'h02a5}};
  // two-clock steps: the comparator sees the registered trial one clock late
  acl_ctrl #(.STEP_CYC(2)) dut (
    .ref_clk_i                (ref_clk_i),
    .arst_n_i                 (arst_n_i),
    .addr_i                   (addr_i),
    .wdata_i                  (wdata_i),
    .wr_i                     (wr_i),
    .rd_i                     (rd_i),
    .rdata_o                  (rdata_o),
    .wait_mode_i              (wait_mode_i),
    .stop_mode_i              (stop_mode_i),
    .break_i                  (break_i),
    .external_trigger_input_i (external_trigger_input_i),
    .cmp_i                    (cmp_i),
    .trial_o                  (trial_o),
    .conv_active_o            (conv_active_o),
    .conv_irq_o               (conv_irq_o),
    .irq_o                    (irq_o)
  );
  acl_cmp_model u_cmp (.trial_i(trial_o), .level_i(level), .cmp_o(cmp_i));
  always #5 ref_clk_i = ~ref_clk_i;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1;
    @(posedge ref_clk_i);
    wr_i <= 0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1;
    @(posedge ref_clk_i);
    rd_i <= 0;
    #1 v = rdata_o;
  endtask
  task automatic chk_res(input logic [15:0] e);
    logic [7:0] h;
    logic [7:0] l;
    rd(`ACL_OFF_RES_HI, h);
    rd(`ACL_OFF_RES_LO, l);
    `CHK("result", e, {h, l})
  endtask
  task automatic conv(input logic [7:0] sc);
    wr(`ACL_OFF_SC, sc);
    for (int n = 0; n < 200 && conv_irq_o !== 1'b1; n++) cyc(1);
  endtask
  task automatic stop_test;
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    arst_n_i <= 1;
    for (int i = 0; i < 3; i++) begin
      level = rows[i][25:16];
      @(posedge ref_clk_i);
      wait_mode_i <= i[0];
      conv(8'h42);
      `CHK("conv irq", 1'b1, conv_irq_o)
      `CHK("active", 1'b0, conv_active_o)
      rd(`ACL_OFF_SC, d);
      `CHK("done", 1'b1, d[7])
      chk_res(rows[i][15:0]);
      cyc(2);
      `CHK("irq cleared", 1'b0, conv_irq_o)
    end
    wr(`ACL_OFF_SC, 8'h02);
    cyc(40);
    `CHK("irq disabled", 1'b0, conv_irq_o)
    rd(`ACL_OFF_SC, d);
    `CHK("done no irq", 8'h82, d)
    rd(3'h7, d);
    `CHK("unmapped", 8'h00, d)
    // an all-ones write has to cut a conversion that is really running
    wr(`ACL_OFF_SC, 8'h02);
    cyc(3);
    `CHK("running", 1'b1, conv_active_o)
    wr(`ACL_OFF_SC, 8'h5f);
    cyc(3);
    `CHK("channel off", 1'b0, conv_active_o)
    cyc(25);
    rd(`ACL_OFF_SC, d);
    `CHK("aborted no done", 8'h5f, d)
    wr(`ACL_OFF_IMASK, 8'h01);
    wr(`ACL_OFF_CFG, 8'h01);
    level = 10'h1c3;
    wr(`ACL_OFF_SC, 8'h42);
    @(posedge ref_clk_i);
    stop_mode_i <= 1;
    conv(8'h42);
    `CHK("stop irq", 1'b1, conv_irq_o)
    `CHK("int", 1'b1, irq_o)
    wr(`ACL_OFF_IMASK, 8'h00);
    cyc(2);
    `CHK("int masked", 1'b0, irq_o)
    wr(`ACL_OFF_IMASK, 8'h01);
    cyc(2);
    `CHK("int unmasked", 1'b1, irq_o)
    wr(`ACL_OFF_ISTAT, 8'h03);
    cyc(2);
    `CHK("int cleared", 1'b0, irq_o)
    @(posedge ref_clk_i);
    stop_mode_i <= 0;
    chk_res(16'h01c3);
    wr(`ACL_OFF_CFG, 8'h00);
    level = 10'h155;
    conv(8'h62);
    level = 10'h0aa;
    @(posedge ref_clk_i);
    stop_mode_i <= 1;
    cyc(3);
    `CHK("stop abort", 1'b0, conv_active_o)
    rd(`ACL_OFF_ISTAT, d);
    `CHK("abort event", 8'h03, d)
    @(posedge ref_clk_i);
    stop_mode_i <= 0;
    cyc(30);
    `CHK("no resume", 1'b0, conv_active_o)
    chk_res(16'h0155);
    for (int b = 0; b < 2; b++) begin
      wr(`ACL_OFF_CFG, b ? 8'h04 : 8'h00);
      conv(8'h42);
      rd(`ACL_OFF_SC, d);
      @(posedge ref_clk_i);
      break_i <= 1;
      rd(`ACL_OFF_RES_LO, d);
      cyc(2);
      `CHK("break flag", b ? 1'b0 : 1'b1, conv_irq_o)
      @(posedge ref_clk_i);
      break_i <= 0;
      rd(`ACL_OFF_RES_LO, d);
      cyc(2);
      `CHK("after break", 1'b0, conv_irq_o)
    end
    // trigger must stay dead even with every other start condition met
    wr(`ACL_OFF_CFG, 8'h03);
    conv(8'h42);
    @(posedge ref_clk_i);
    external_trigger_input_i <= 1;
    cyc(3);
    `CHK("no trigger", 1'b0, conv_active_o)
    @(posedge ref_clk_i);
    arst_n_i                 <= 0;
    external_trigger_input_i <= 0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1;
    cyc(1);
    `CHK("irq reset", 1'b0, conv_irq_o)
    `CHK("int reset", 1'b0, irq_o)
    rd(`ACL_OFF_SC, d);
    `CHK("sc reset", `ACL_SC_RST, d)
    rd(`ACL_OFF_CFG, d);
    `CHK("cfg reset", `ACL_CFG_RST, d)
    stop_test();
  end
endmodule // acl_ctrl_test
